//--- rtl/bra_pkg.sv
// Constants, types and timing for the bridge converter readout block
`default_nettype none
package bra_pkg;
	// Clock of this logic in ns
	localparam int          CLK_NS        = 10;
	// Master clock divisors per conversion at slow and fast rate
	localparam longint      MCLK_DIV_SLOW = 491520;
	localparam longint      MCLK_DIV_FAST = 61440;
	// Nominal master clock period is 78125/384 ns (4.9152 MHz)
	localparam longint      MCLK_NUM      = 78125;
	localparam longint      MCLK_DEN      = 384;
	localparam longint      CONV_SLOW_NS  = MCLK_DIV_SLOW * MCLK_NUM / MCLK_DEN;
	localparam longint      CONV_FAST_NS  = MCLK_DIV_FAST * MCLK_NUM / MCLK_DEN;
	// Settling, calibration and update times in ns
	localparam longint      SETTLE_FAST_NS = 51000000;
	localparam longint      SETTLE_SLOW_NS = 401000000;
	localparam longint      CAL_FAST_NS    = 101280000;
	localparam longint      CAL_SLOW_NS    = 801020000;
	localparam longint      UPDATE_NS      = 39000;
	// Cycle counts, longest times rounded down, least times rounded up
	localparam int CONV_FAST_CYC   = int'(CONV_FAST_NS / CLK_NS);
	localparam int CONV_SLOW_CYC   = int'(CONV_SLOW_NS / CLK_NS);
	localparam int SETTLE_FAST_CYC = int'(SETTLE_FAST_NS / CLK_NS);
	localparam int SETTLE_SLOW_CYC = int'(SETTLE_SLOW_NS / CLK_NS);
	localparam int CAL_FAST_CYC    = int'(CAL_FAST_NS / CLK_NS);
	localparam int CAL_SLOW_CYC    = int'(CAL_SLOW_NS / CLK_NS);
	localparam int UPDATE_CYC_I    = int'((UPDATE_NS + CLK_NS - 1) / CLK_NS);
	// Timer width and the update length at that width
	localparam int          CNT_W      = 27;
	localparam logic [26:0] UPDATE_CYC = UPDATE_CYC_I[26:0];
	// Result word and readout clock counts
	localparam int          DATA_W     = 24;
	localparam int          RAW_W      = 26;
	localparam logic [4:0]  BITS_LAST  = 5'h18;
	localparam logic [4:0]  BIT_FORCE  = 5'h19;
	localparam logic [4:0]  BIT_CAL    = 5'h1a;
	// Full-scale limits
	localparam logic signed [25:0] RAW_POS_FS  = 26'sh07fffff;
	localparam logic signed [25:0] RAW_NEG_FS  = 26'sh3800000;
	localparam logic [23:0]        CODE_POS_FS = 24'h7fffff;
	localparam logic [23:0]        CODE_NEG_FS = 24'h800000;
	// Register offsets
	localparam logic [7:0] OFS_CTRL   = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_MASK   = 8'h08;
	localparam logic [7:0] OFS_RESULT = 8'h0c;
	localparam logic [7:0] OFS_STATE  = 8'h10;
	// Control bit positions and reset values
	localparam int         CTRL_CAL_BIT = 0;
	localparam logic [3:0] MASK_RESET   = 4'h0;
	// Event flags, also the layout of status and mask
	typedef struct packed {
		logic cal_done;
		logic settled;
		logic overrun;
		logic ready;
	} bra_evt_s;
	// Edges seen on the watched pins
	typedef struct packed {
		logic rise;
		logic fall;
		logic chan_change;
	} bra_edge_s;
	// Sequencer phases
	typedef enum logic [1:0] {
		ST_SETTLE,
		ST_UPDATE,
		ST_CONV,
		ST_CAL
	} bra_state_e;
endpackage : bra_pkg
`default_nettype wire

//--- rtl/bra_pin_watch.sv
// Edge detection for the serial clock and the channel-select pins
`default_nettype none
module bra_pin_watch
	import bra_pkg::*;
(
	// Clock and reset
	input  wire logic      clk_i,
	input  wire logic      reset_n_i,
	// Pins
	input  wire logic      sclk_i,
	input  wire logic      channel_select_low_i,
	input  wire logic      channel_select_high_i,
	// Edges
	output bra_edge_s      edge_o
);
	logic       sclk_reg;
	logic       sclk_next;
	logic [1:0] chan_reg;
	logic [1:0] chan_next;

	// Previous pin levels
	always_comb
	begin
		sclk_next = sclk_i;
		chan_next = {channel_select_high_i, channel_select_low_i};
	end

	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			sclk_reg <= 1'b0;
			chan_reg <= 2'h0;
		end
		else
		begin
			sclk_reg <= sclk_next;
			chan_reg <= chan_next;
		end
	end

	// Edges against the previous level
	always_comb
	begin
		edge_o.rise        = sclk_i & ~sclk_reg;
		edge_o.fall        = ~sclk_i & sclk_reg;
		edge_o.chan_change = (chan_next != chan_reg);
	end
endmodule : bra_pin_watch
`default_nettype wire

//--- rtl/bra_readout.sv
// Sequencer and serial readout of the bridge converter
//
// How it works
// R1: Period timer reloads results without any command
// R2: Channel change raises line, waits settle time
// R3: Host discards four results after abrupt change
// R4: Period is master divisor 491520 or 61440
// R5: Results are 24-bit two's complement words
// R6: Raw values clip at 7fffff and 800000
// R7: Line low announces; first rise shows MSB
// R8: Each further rise shows next lower bit
// R9: Twenty-fifth rise forces line high until ready
// R10: Otherwise last bit stays until update raises
// R11: Host waits for low line before clocking
// R12: Unread result overwritten after one period
// R13: Host stays off during 39 us update
// R14: Host gives two extra clocks for calibration
// R15: Falling 26th clock starts calibration, inputs cut
// R16: Calibration ends with settled result, line low
// R17: Host keeps clock quiet while calibrating
// R18: Durations scale with master clock period
// R19: Host samples after rise, builds signed word
`default_nettype none
module bra_readout
	import bra_pkg::*;
#(
	// Long counts, shortened in simulation
	parameter int CONV_FAST   = CONV_FAST_CYC,
	parameter int CONV_SLOW   = CONV_SLOW_CYC,
	parameter int SETTLE_FAST = SETTLE_FAST_CYC,
	parameter int SETTLE_SLOW = SETTLE_SLOW_CYC,
	parameter int CAL_FAST    = CAL_FAST_CYC,
	parameter int CAL_SLOW    = CAL_SLOW_CYC
)
(
	// Clock and reset
	input  wire logic             clk_i,
	input  wire logic             reset_n_i,
	// Converter pins
	input  wire logic             speed_i,
	input  wire logic             channel_select_low_i,
	input  wire logic             channel_select_high_i,
	input  wire logic             sclk_i,
	output logic                  ready_and_serial_out_o,
	// Modulator side
	input  wire logic [RAW_W-1:0] raw_i,
	output logic                  input_disconnect_o,
	// Register port
	input  wire logic [7:0]       addr_i,
	input  wire logic [31:0]      wdata_i,
	input  wire logic             wr_i,
	input  wire logic             rd_i,
	output logic [31:0]           rdata_o,
	// Interrupt
	output logic                  irq_o
);
	bra_edge_s           pin_edge;
	bra_state_e          state_reg;
	bra_state_e          state_next;
	logic [CNT_W-1:0]    cnt_reg;
	logic [CNT_W-1:0]    cnt_next;
	logic [DATA_W-1:0]   shift_reg;
	logic [DATA_W-1:0]   shift_next;
	logic [DATA_W-1:0]   result_reg;
	logic [DATA_W-1:0]   result_next;
	logic [4:0]          bit_reg;
	logic [4:0]          bit_next;
	logic                dout_reg;
	logic                dout_next;
	logic                disc_reg;
	logic                disc_next;
	logic                pending_reg;
	logic                pending_next;
	bra_evt_s            evt;
	bra_evt_s            status_reg;
	bra_evt_s            status_next;
	bra_evt_s            mask_reg;
	bra_evt_s            mask_next;
	logic                irq_reg;
	logic                irq_next;
	logic [31:0]         rdata_reg;
	logic [31:0]         rdata_next;
	logic                soft_cal;
	logic                load;
	logic [CNT_W-1:0]    conv_cyc;
	logic [CNT_W-1:0]    settle_cyc;
	logic [CNT_W-1:0]    cal_cyc;

	// Clip the filter value to the 24-bit code range
	function automatic logic [DATA_W-1:0] bra_sat24(
		input logic [RAW_W-1:0] v
	);
		logic signed [RAW_W-1:0] s;
		s = $signed(v);
		if (s > RAW_POS_FS)
			return CODE_POS_FS; // R6
		else if (s < RAW_NEG_FS)
			return CODE_NEG_FS; // R6
		else
			return v[DATA_W-1:0]; // R5
	endfunction : bra_sat24

	// Pick the count for the rate pin
	function automatic logic [CNT_W-1:0] bra_rate(
		input logic sel_fast,
		input int   fast,
		input int   slow
	);
		logic [31:0] n;
		n = sel_fast ? fast : slow;
		return n[CNT_W-1:0];
	endfunction : bra_rate

	// Pin edges
	bra_pin_watch u_watch (
		.clk_i                 (clk_i),
		.reset_n_i             (reset_n_i),
		.sclk_i                (sclk_i),
		.channel_select_low_i  (channel_select_low_i),
		.channel_select_high_i (channel_select_high_i),
		.edge_o                (pin_edge)
	);

	// Durations at the selected rate
	always_comb
	begin
		conv_cyc   = bra_rate(speed_i, CONV_FAST, CONV_SLOW); // R4 R18
		settle_cyc = bra_rate(speed_i, SETTLE_FAST, SETTLE_SLOW); // R18
		cal_cyc    = bra_rate(speed_i, CAL_FAST, CAL_SLOW); // R18
	end

	// Software calibration request from the control register
	assign soft_cal = wr_i && (addr_i == OFS_CTRL) && wdata_i[CTRL_CAL_BIT];

	// Sequencer and shifter next state
	always_comb
	begin
		state_next   = state_reg;
		cnt_next     = cnt_reg + 27'h1;
		shift_next   = shift_reg;
		result_next  = result_reg;
		bit_next     = bit_reg;
		dout_next    = dout_reg;
		disc_next    = 1'b0;
		pending_next = pending_reg;
		load         = 1'b0;
		evt          = '0;
		if (pin_edge.chan_change)
		begin
			state_next = ST_SETTLE; // R2
			cnt_next   = '0;
			dout_next  = 1'b1; // R2
		end
		else
		begin
			case (state_reg)
				ST_SETTLE:
				begin
					dout_next = 1'b1; // R2
					if (cnt_reg >= settle_cyc - 27'h1)
					begin
						load        = 1'b1; // R2
						evt.settled = 1'b1;
					end
				end
				ST_UPDATE:
				begin
					dout_next = 1'b1; // R10
					if (cnt_reg >= UPDATE_CYC - 27'h1)
						load = 1'b1; // R1
				end
				ST_CAL:
				begin
					dout_next = 1'b1;
					disc_next = 1'b1; // R15
					if (cnt_reg >= cal_cyc - 27'h1)
					begin
						load         = 1'b1; // R16
						evt.cal_done = 1'b1;
					end
				end
				ST_CONV:
				begin
					if (cnt_reg >= conv_cyc - 27'h1)
					begin
						state_next = ST_UPDATE; // R1
						cnt_next   = '0;
						dout_next  = 1'b1; // R10
						evt.overrun = pending_reg; // R12
					end
					else if (soft_cal ||
						(pin_edge.fall && bit_reg == BIT_CAL))
					begin
						state_next = ST_CAL; // R15
						cnt_next   = '0;
						dout_next  = 1'b1;
						disc_next  = 1'b1; // R15
					end
					else if (pin_edge.rise)
					begin
						pending_next = 1'b0;
						if (bit_reg < BITS_LAST)
						begin
							dout_next  = shift_reg[DATA_W-1]; // R7 R8
							shift_next = {shift_reg[DATA_W-2:0], 1'b0}; // R8
							bit_next   = bit_reg + 5'h1;
						end
						else if (bit_reg == BITS_LAST)
						begin
							dout_next = 1'b1; // R9
							bit_next  = BIT_FORCE;
						end
						else if (bit_reg == BIT_FORCE)
							bit_next = BIT_CAL;
					end
				end
				default:
				begin
					state_next = ST_SETTLE;
					cnt_next   = '0;
					dout_next  = 1'b1;
				end
			endcase
		end
		// Present a new result and start a fresh period
		if (load)
		begin
			result_next  = bra_sat24(raw_i); // R6
			shift_next   = bra_sat24(raw_i);
			bit_next     = '0;
			dout_next    = 1'b0; // R7
			pending_next = 1'b1;
			state_next   = ST_CONV;
			cnt_next     = UPDATE_CYC; // R1
			evt.ready    = 1'b1;
		end
	end

	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			state_reg   <= ST_SETTLE;
			cnt_reg     <= '0;
			shift_reg   <= '0;
			result_reg  <= '0;
			bit_reg     <= '0;
			dout_reg    <= 1'b1;
			disc_reg    <= 1'b0;
			pending_reg <= 1'b0;
		end
		else
		begin
			state_reg   <= state_next;
			cnt_reg     <= cnt_next;
			shift_reg   <= shift_next;
			result_reg  <= result_next;
			bit_reg     <= bit_next;
			dout_reg    <= dout_next;
			disc_reg    <= disc_next;
			pending_reg <= pending_next;
		end
	end

	// Status, mask, interrupt and read data next values
	always_comb
	begin
		status_next = status_reg;
		mask_next   = mask_reg;
		rdata_next  = '0;
		if (rd_i)
		begin
			case (addr_i)
				OFS_STATUS:
				begin
					rdata_next  = {28'h0, status_reg};
					status_next = '0;
				end
				OFS_MASK:   rdata_next = {28'h0, mask_reg};
				OFS_RESULT: rdata_next = {8'h0, result_reg};
				OFS_STATE:  rdata_next = {16'h0, 6'h0, state_reg, 3'h0, bit_reg};
				default:    rdata_next = '0;
			endcase
		end
		if (wr_i && addr_i == OFS_MASK)
			mask_next = wdata_i[3:0];
		// Events set over a clearing read
		status_next = status_next | evt;
		irq_next    = |(status_reg & mask_reg);
	end

	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			status_reg <= '0;
			mask_reg   <= MASK_RESET;
			irq_reg    <= 1'b0;
			rdata_reg  <= '0;
		end
		else
		begin
			status_reg <= status_next;
			mask_reg   <= mask_next;
			irq_reg    <= irq_next;
			rdata_reg  <= rdata_next;
		end
	end

	// Outputs straight from flops
	assign ready_and_serial_out_o = dout_reg;
	assign input_disconnect_o     = disc_reg;
	assign rdata_o                = rdata_reg;
	assign irq_o                  = irq_reg;
endmodule : bra_readout
`default_nettype wire

//--- test/bra_readout_sva.sv
// Port checker for the converter readout block
`default_nettype none
module bra_readout_chk
	import bra_pkg::*;
#(
	parameter int CONV_FAST = CONV_FAST_CYC,
	parameter int CONV_SLOW = CONV_SLOW_CYC
)
(
	// Clock and reset
	input wire logic        clk_i,
	input wire logic        reset_n_i,
	// Converter pins
	input wire logic        speed_i,
	input wire logic        channel_select_low_i,
	input wire logic        channel_select_high_i,
	input wire logic        sclk_i,
	input wire logic        ready_and_serial_out_o,
	input wire logic        input_disconnect_o,
	// Register port
	input wire logic [7:0]  addr_i,
	input wire logic        rd_i,
	input wire logic [31:0] rdata_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic        sclk_q;
	logic        line_q;
	logic        rise_q;
	logic        steady_q;
	logic [1:0]  sel_q;
	logic [4:0]  rises;
	logic [31:0] per_cnt;
	logic        rise;
	logic        ann;
	logic        chg;
	// Announce is a line fall not caused by a clock rise
	assign rise = sclk_i & ~sclk_q;
	assign ann  = line_q & ~ready_and_serial_out_o & ~rise_q;
	assign chg  = sel_q != {channel_select_high_i, channel_select_low_i};
	// History, rises and cycles since the last announce
	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			sclk_q   <= 1'b0;
			line_q   <= 1'b1;
			rise_q   <= 1'b0;
			steady_q <= 1'b0;
			sel_q    <= 2'h0;
			rises    <= 5'h0;
			per_cnt  <= 32'h0;
		end
		else
		begin
			sclk_q   <= sclk_i;
			line_q   <= ready_and_serial_out_o;
			rise_q   <= rise;
			sel_q    <= {channel_select_high_i, channel_select_low_i};
			steady_q <= (chg | input_disconnect_o) ? 1'b0 : (ann | steady_q);
			rises    <= ann ? 5'h0 : rises + {4'h0, rise && rises != 5'h1f};
			per_cnt  <= ann ? 32'h0 : per_cnt + 32'h1;
		end
	end
	default clocking dc @(posedge clk_i);
	endclocking
	default disable iff (!reset_n_i);
	chan_high_a: assert property (
		chg |-> ##[1:2] ready_and_serial_out_o [*8])
		else $error("line not held high after channel change");
	period_a: assert property (
		ann && steady_q |-> per_cnt == (speed_i ? CONV_FAST : CONV_SLOW) - 1)
		else $error("conversion period wrong");
	force_high_a: assert property (
		rise && rises == 5'd24 |=> ready_and_serial_out_o [*8])
		else $error("extra clock did not force line high");
	cal_start_a: assert property (
		rises == 5'd26 && sclk_q && !sclk_i |-> ##[1:2] input_disconnect_o)
		else $error("calibration not started");
	cal_hold_a: assert property (
		$rose(input_disconnect_o) |-> ready_and_serial_out_o [*8])
		else $error("line low during calibration");
	cal_done_a: assert property (
		$fell(input_disconnect_o) && !$past(chg) |-> ##[0:1]
		!ready_and_serial_out_o)
		else $error("calibration end without result");
	rd_idle_a: assert property (
		!$past(rd_i) |-> rdata_o == 32'h0)
		else $error("read data outside answer cycle");
	unmapped_a: assert property (
		rd_i && addr_i == 8'h14 |=> rdata_o == 32'h0)
		else $error("unmapped read not zero");
endmodule : bra_readout_chk
bind bra_readout bra_readout_chk #(
	.CONV_FAST(CONV_FAST),
	.CONV_SLOW(CONV_SLOW)
) chk_u (
	.clk_i(clk_i),
	.reset_n_i(reset_n_i),
	.speed_i(speed_i),
	.channel_select_low_i(channel_select_low_i),
	.channel_select_high_i(channel_select_high_i),
	.sclk_i(sclk_i),
	.ready_and_serial_out_o(ready_and_serial_out_o),
	.input_disconnect_o(input_disconnect_o),
	.addr_i(addr_i),
	.rd_i(rd_i),
	.rdata_o(rdata_o)
);
`default_nettype wire

//--- test/bra_host_model.sv
// Host model that clocks results out of the readout block
`default_nettype none
module bra_host_model
(
	// Clock and control
	input  wire logic       clk_i,
	input  wire logic       start_i,
	input  wire logic [4:0] count_i,
	input  wire logic       slow_i,
	// Link and result
	input  wire logic       line_i,
	output logic            sclk_o,
	output logic [23:0]     word_o,
	output logic            done_o
);
	timeunit 1ns;
	timeprecision 1ps;
	int w;
	int hp;
	// Wait for a line fall, then give the clocks
	initial
	begin
		sclk_o = 1'b0;
		word_o = 24'h0;
		done_o = 1'b0;
		forever
		begin
			@(posedge clk_i);
			if (start_i)
			begin
				done_o <= 1'b0;
				hp = slow_i ? 20 : 3;
				for (w = 0; w < 40000 && !line_i; w++)
					@(posedge clk_i);
				for (w = 0; w < 40000 && line_i; w++)
					@(posedge clk_i);
				for (int k = 0; k < count_i; k++)
				begin
					sclk_o <= 1'b1;
					repeat (hp) @(posedge clk_i);
					sclk_o <= 1'b0;
					if (k < 24)
						word_o <= {word_o[22:0], line_i};
					repeat (hp) @(posedge clk_i);
				end
				done_o <= 1'b1;
			end
		end
	end
endmodule : bra_host_model
`default_nettype wire

//--- test/bra_readout_tb.sv
// Self-checking bench for the converter readout block
`default_nettype none
module bra_readout_tb
	import bra_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int SETTLE = 9000;
	localparam int SETTLE_S = 17000;
	logic                    clk = 1'b0;
	logic                    rst_n = 1'b0;
	logic                    sel_lo = 1'b0;
	logic                    sel_hi = 1'b0;
	logic signed [RAW_W-1:0] raw = 26'sh0ffffff;
	logic [7:0]              addr = 8'h0;
	logic [31:0]             wdata = 32'h0;
	logic                    wr = 1'b0;
	logic                    rd = 1'b0;
	logic                    start = 1'b0;
	logic [4:0]              cnt = 5'h19;
	logic                    slow = 1'b0;
	logic                    speed = 1'b1;
	logic                    sclk;
	logic                    line;
	logic                    disc;
	logic                    irq;
	logic                    done;
	logic [23:0]             word;
	logic [31:0]             rdata;
	logic [31:0]             d;
	integer                  seed = 32'h4f2bc732;
	int                      err_count = 0;
	int                      compares = 0;
	int                      i;
	int                      n;
	// Clock
	always #5 clk = ~clk;
	bra_readout #(
		.CONV_FAST(6000), .CONV_SLOW(16000), .SETTLE_FAST(SETTLE),
		.SETTLE_SLOW(SETTLE_S), .CAL_FAST(5000), .CAL_SLOW(20000)
	) dut_u (
		.clk_i(clk), .reset_n_i(rst_n), .speed_i(speed),
		.channel_select_low_i(sel_lo), .channel_select_high_i(sel_hi),
		.sclk_i(sclk), .ready_and_serial_out_o(line), .raw_i(raw),
		.input_disconnect_o(disc), .addr_i(addr), .wdata_i(wdata),
		.wr_i(wr), .rd_i(rd), .rdata_o(rdata), .irq_o(irq)
	);
	bra_host_model host_u (
		.clk_i(clk), .start_i(start), .count_i(cnt), .slow_i(slow),
		.line_i(line), .sclk_o(sclk), .word_o(word), .done_o(done)
	);
	// Expected code of a raw filter value
	function automatic logic [23:0] clip(input logic signed [25:0] v);
		if (v > RAW_POS_FS)
			return CODE_POS_FS;
		if (v < RAW_NEG_FS)
			return CODE_NEG_FS;
		return v[23:0];
	endfunction : clip
	task automatic wrap_up();
		$display("compares %0d err_count %0d", compares, err_count);
		if (err_count == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : wrap_up
	task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp)
		begin
			err_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : cmp_word
	task automatic cmp_bit(input logic got, input logic exp);
		cmp_word({31'h0, got}, {31'h0, exp});
	endtask : cmp_bit
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
		addr <= a;
		wdata <= v;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wr_reg
	task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(posedge clk);
		v = rdata;
	endtask : rd_reg
	task automatic go(input logic [4:0] c, input logic s);
		cnt <= c;
		slow <= s;
		start <= 1'b1;
		@(posedge clk);
		start <= 1'b0;
	endtask : go
	task automatic fin();
		int w;
		@(posedge clk);
		for (w = 0; w < 60000 && done !== 1'b1; w++)
			@(posedge clk);
		if (w == 60000)
		begin
			err_count++;
			wrap_up();
		end
	endtask : fin
	task automatic read(input logic [4:0] c, input logic s);
		go(c, s);
		fin();
	endtask : read
	// Main sequence
	initial
	begin
		repeat (12) @(posedge clk);
		cmp_bit(line, 1'b1);
		rst_n <= 1'b1;
		rd_reg(OFS_MASK, d);
		cmp_word(d, 32'h0);
		wr_reg(OFS_MASK, 32'h1);
		rd_reg(8'h14, d);
		cmp_word(d, 32'h0);
		// Full reads: both clip limits, then random words
		for (i = 0; i < 4; i++)
		begin
			read(5'd25, i[0]);
			cmp_word({8'h0, word}, {8'h0, clip(raw)});
			cmp_bit(line, 1'b1);
			cmp_bit(irq, 1'b1);
			rd_reg(OFS_STATUS, d);
			cmp_bit(d[0], 1'b1);
			cmp_bit(d[1], 1'b0);
			cmp_bit(d[2], i == 0);
			@(posedge clk);
			cmp_bit(irq, 1'b0);
			rd_reg(OFS_RESULT, d);
			cmp_word(d, {8'h0, clip(raw)});
			raw <= (i == 0) ? 26'sh2000000 : (i == 3) ? 26'sh0000002 :
				26'($signed(24'($random(seed))));
		end
		// Abrupt input step: four results thrown away unread
		for (i = 0; i < 4; i++)
			read(5'd0, 1'b0);
		rd_reg(OFS_STATUS, d);
		cmp_bit(d[1], 1'b1);
		// Short read leaves the last bit on the line
		read(5'd24, 1'b1);
		repeat (50) @(posedge clk);
		cmp_bit(line, 1'b0);
		cmp_word({8'h0, word}, 32'h2);
		// Two extra clocks start a calibration
		raw <= 26'($signed(24'($random(seed))));
		read(5'd26, 1'b0);
		cmp_bit(disc, 1'b1);
		rd_reg(OFS_STATE, d);
		cmp_word(d, {22'h0, 2'h3, 3'h0, BIT_CAL});
		read(5'd25, 1'b0);
		cmp_word({8'h0, word}, {8'h0, clip(raw)});
		cmp_bit(disc, 1'b0);
		rd_reg(OFS_STATUS, d);
		cmp_bit(d[3], 1'b1);
		// Register request starts a calibration too
		wr_reg(OFS_CTRL, 32'h1);
		@(posedge clk);
		cmp_bit(disc, 1'b1);
		read(5'd25, 1'b0);
		cmp_word({8'h0, word}, {8'h0, clip(raw)});
		cmp_bit(disc, 1'b0);
		// Slow rate with a channel change, a second one restarts it
		sel_lo <= 1'b1;
		speed <= 1'b0;
		go(5'd25, 1'b0);
		for (n = 0; n < 20000 && line !== 1'b0; n++)
		begin
			if (n == 100)
				sel_hi <= 1'b1;
			@(posedge clk);
		end
		cmp_bit(n >= SETTLE_S + 98 && n <= SETTLE_S + 106, 1'b1);
		fin();
		cmp_word({8'h0, word}, {8'h0, clip(raw)});
		wrap_up();
	end
endmodule : bra_readout_tb
`default_nettype wire
